// *** verilog/scr_chan_ctrl.sv ***
`timescale 1ns/1ps
`include "scr_defines.svh"
module scr_chan_ctrl
  import scr_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire scr_alarm_t alarm,
  output logic [3:0] chan_soft_reset,
  output logic [3:0] chan_test_mode,
  output logic irq
);

  if (ADDR_W < `SCR_MIN_ADDR_W || ADDR_W > `SCR_MAX_ADDR_W) begin : g_bad_addr_w
    $error("ADDR_W cannot hold the register addresses");
  end

  function automatic logic [2:0] scr_decode(input logic [31:0] addr);
    case (addr)
      `SCR_ADDR_CHAN_A: scr_decode = 3'h0;
      `SCR_ADDR_CHAN_B: scr_decode = 3'h1;
      `SCR_ADDR_CHAN_C: scr_decode = 3'h2;
      `SCR_ADDR_CHAN_D: scr_decode = 3'h3;
      `SCR_ADDR_GLOBAL: scr_decode = `SCR_IDX_GLOBAL;
      `SCR_ADDR_IRQ_STAT: scr_decode = `SCR_IDX_IRQ_STAT;
      `SCR_ADDR_IRQ_MASK: scr_decode = `SCR_IDX_IRQ_MASK;
      default: scr_decode = `SCR_IDX_NONE;
    endcase
  endfunction

  scr_chan_ctrl_t chan_ff [`SCR_NUM_CHAN];
  scr_global_ctrl_t global_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic irq_ff;
  logic [3:0] soft_reset_ff;
  logic [3:0] test_mode_ff;

  scr_wr_state_t wr_st_ff;
  scr_rd_state_t rd_st_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [7:0] w_byte_ff;
  logic w_lane_ff;
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  logic [1:0] bresp_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [7:0] rd_byte;
  logic [3:0] alarm_event;
  logic [3:0] stat_clr;
  logic [3:0] chan_srst_v;
  logic [3:0] chan_test_v;

  // One clock domain, so every assertion below shares this clock and reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign arready = arready_ff;
  assign bvalid = wr_st_ff[0];
  assign bresp = bresp_ff;
  assign rvalid = rd_st_ff[0];
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign irq = irq_ff;
  assign chan_soft_reset = soft_reset_ff;
  assign chan_test_mode = test_mode_ff;

  // Address and data may arrive in either order; a held half waits for the other
  assign aw_hs = awvalid & awready_ff;
  assign w_hs = wvalid & wready_ff;
  assign ar_hs = arvalid & arready_ff;
  assign wr_addr = aw_got_ff ? aw_addr_ff : awaddr;
  assign wr_byte = w_got_ff ? w_byte_ff : wdata[7:0];
  assign wr_lane = w_got_ff ? w_lane_ff : wstrb[0];
  assign do_wr = (aw_got_ff | aw_hs) & (w_got_ff | w_hs) & (wr_st_ff == SCR_WR_IDLE);
  assign wr_sel = scr_decode(32'(wr_addr));
  assign rd_sel = scr_decode(32'(araddr));
  // Registers are 8 bits wide, so only byte lane 0 stores anything
  assign wr_en = do_wr & wr_lane;
  assign stat_clr = (wr_en && wr_sel == `SCR_IDX_IRQ_STAT) ? wr_byte[3:0] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_ff <= SCR_WR_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bresp_ff <= `SCR_RESP_OKAY;
      aw_addr_ff <= '0;
      w_byte_ff <= 8'h00;
      w_lane_ff <= 1'b0;
    end else begin
      case (wr_st_ff)
        SCR_WR_IDLE: begin
          if (do_wr) begin
            wr_st_ff <= SCR_WR_RESP;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bresp_ff <= (wr_sel == `SCR_IDX_NONE) ? `SCR_RESP_SLVERR : `SCR_RESP_OKAY;
          end else begin
            if (aw_hs) begin
              aw_got_ff <= 1'b1;
              aw_addr_ff <= awaddr;
              awready_ff <= 1'b0;
            end else begin
              awready_ff <= ~aw_got_ff;
            end
            if (w_hs) begin
              w_got_ff <= 1'b1;
              w_byte_ff <= wdata[7:0];
              w_lane_ff <= wstrb[0];
              wready_ff <= 1'b0;
            end else begin
              wready_ff <= ~w_got_ff;
            end
          end
        end
        SCR_WR_RESP: begin
          if (bready) begin
            wr_st_ff <= SCR_WR_IDLE;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
          end
        end
        default: begin
          wr_st_ff <= SCR_WR_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      3'h0: rd_byte = chan_ff[0];
      3'h1: rd_byte = chan_ff[1];
      3'h2: rd_byte = chan_ff[2];
      3'h3: rd_byte = chan_ff[3];
      `SCR_IDX_GLOBAL: rd_byte = global_ff;
      `SCR_IDX_IRQ_STAT: rd_byte = {4'h0, irq_stat_ff};
      `SCR_IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask_ff};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_ff <= SCR_RD_IDLE;
      arready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `SCR_RESP_OKAY;
    end else begin
      case (rd_st_ff)
        SCR_RD_IDLE: begin
          if (ar_hs) begin
            rd_st_ff <= SCR_RD_DATA;
            arready_ff <= 1'b0;
            rdata_ff <= {24'h00_0000, rd_byte};
            rresp_ff <= (rd_sel == `SCR_IDX_NONE) ? `SCR_RESP_SLVERR : `SCR_RESP_OKAY;
          end else begin
            arready_ff <= 1'b1;
          end
        end
        SCR_RD_DATA: begin
          if (rready) begin
            rd_st_ff <= SCR_RD_IDLE;
            arready_ff <= 1'b1;
          end
        end
        default: begin
          rd_st_ff <= SCR_RD_IDLE;
        end
      endcase
    end
  end

  // Only the documented control bits take writes; reserved bits keep their reset value
  for (genvar i = 0; i < `SCR_NUM_CHAN; i++) begin : g_chan
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        chan_ff[i] <= `SCR_CHAN_RST;
      end else if (wr_en && wr_sel == 3'(i)) begin
        chan_ff[i] <= (chan_ff[i] & ~`SCR_CHAN_WMASK) | (wr_byte & `SCR_CHAN_WMASK);
      end
    end

    // Channel block wins over the irq mask; quad block wins over both
    assign alarm_event[i] = (alarm.tx[i] | alarm.rx[i]) & ~chan_ff[i].alarm_block
                            & ~global_ff.quad_alarm_block;
    assign chan_srst_v[i] = chan_ff[i].soft_reset;
    assign chan_test_v[i] = chan_ff[i].test_enable;

    a_chan_reset_value: assert property ($rose(aresetn) |-> chan_ff[i] == `SCR_CHAN_RST)
      else $error("channel register not at reset value");
    a_chan_rsvd_zero: assert property (
      !chan_ff[i].rsvd_lead && chan_ff[i].rsvd_mid == 4'h0)
      else $error("channel reserved bits not zero");
    a_chan_alarm_blocked: assert property (
      (chan_ff[i].alarm_block && !irq_stat_ff[i]) |=> !irq_stat_ff[i])
      else $error("blocked channel alarm reached status");
    a_quad_alarm_blocked: assert property (
      (global_ff.quad_alarm_block && !irq_stat_ff[i]) |=> !irq_stat_ff[i])
      else $error("quad block did not stop alarm");
    a_soft_rst_drive: assert property (chan_ff[i].soft_reset |=> chan_soft_reset[i])
      else $error("channel soft reset not driven");
    // Both reset sources must be low before the channel leaves soft reset
    a_soft_rst_release: assert property (
      (!chan_ff[i].soft_reset && !global_ff.quad_soft_reset) |=> !chan_soft_reset[i])
      else $error("channel soft reset stuck");
    // Configuration survives a soft reset unless software rewrites it
    a_soft_rst_keeps: assert property (
      (chan_ff[i].soft_reset && !(wr_en && wr_sel == 3'(i))) |=> $stable(chan_ff[i]))
      else $error("soft reset disturbed configuration");
    a_soft_rst_hold: assert property (
      $fell(chan_ff[i].soft_reset) |-> $past(wr_en && wr_sel == 3'(i)))
      else $error("soft reset cleared without a write");
    a_test_en_drive: assert property (chan_ff[i].test_enable |=> chan_test_mode[i])
      else $error("channel test mode not driven");
    a_test_en_off: assert property (
      (!chan_ff[i].test_enable && !global_ff.quad_test_override) |=> !chan_test_mode[i])
      else $error("channel in test mode without enable");
    a_alarm_sets_stat: assert property (alarm_event[i] |=> irq_stat_ff[i])
      else $error("unblocked alarm lost");
    // Set beats clear, so only a clear without a new alarm empties the bit
    a_stat_w1c: assert property ((stat_clr[i] && !alarm_event[i]) |=> !irq_stat_ff[i])
      else $error("status bit not cleared");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_ff <= `SCR_GLOBAL_RST;
    end else if (wr_en && wr_sel == `SCR_IDX_GLOBAL) begin
      global_ff <= (global_ff & ~`SCR_GLOBAL_WMASK) | (wr_byte & `SCR_GLOBAL_WMASK);
    end
  end

  // A new alarm in the same cycle as a clear stays recorded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= 4'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~stat_clr) | alarm_event;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_ff <= `SCR_IRQ_MASK_RST;
    end else if (wr_en && wr_sel == `SCR_IDX_IRQ_MASK) begin
      irq_mask_ff <= wr_byte[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Registered so the channel logic sees a glitch-free reset and mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset_ff <= 4'h0;
      test_mode_ff <= 4'h0;
    end else begin
      soft_reset_ff <= chan_srst_v | {4{global_ff.quad_soft_reset}};
      test_mode_ff <= chan_test_v | {4{global_ff.quad_test_override}};
    end
  end

  sequence s_wr_taken;
    do_wr;
  endsequence

  // The response sits alone: both readies stay low until bready takes it
  sequence s_wr_answered;
    bvalid && !awready && !wready;
  endsequence

  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  sequence s_rd_answered;
    rvalid && !arready;
  endsequence

  a_wr_answer: assert property (s_wr_taken |=> s_wr_answered)
    else $error("write not answered next cycle");
  a_rd_answer: assert property (s_rd_taken |=> s_rd_answered)
    else $error("read not answered next cycle");
  a_wr_unmapped: assert property (
    (do_wr && wr_sel == `SCR_IDX_NONE) |=> bresp == `SCR_RESP_SLVERR)
    else $error("unmapped write not refused");
  a_glb_reset_value: assert property ($rose(aresetn) |-> global_ff == `SCR_GLOBAL_RST)
    else $error("global register not at reset value");
  a_glb_override_zero: assert property (
    $rose(aresetn) |-> !global_ff.quad_test_override)
    else $error("test override set after reset");
  // Power-down and reserved bits are read-only here, so they never leave reset
  a_glb_fixed_bits: assert property (
    (global_ff & ~`SCR_GLOBAL_WMASK) == (`SCR_GLOBAL_RST & ~`SCR_GLOBAL_WMASK))
    else $error("global fixed bits changed");
  a_test_mode_map: assert property (
    1'b1 |=> chan_test_mode == ($past(chan_test_v) | {4{$past(global_ff.quad_test_override)}}))
    else $error("test mode output wrong");
  a_test_override_all: assert property (
    global_ff.quad_test_override |=> &chan_test_mode)
    else $error("override did not force test mode");
  a_quad_soft_rst: assert property (global_ff.quad_soft_reset |=> &chan_soft_reset)
    else $error("quad soft reset not applied");
  a_irq_level: assert property (##1 irq == $past(|(irq_stat_ff & irq_mask_ff)))
    else $error("irq level wrong");
  a_bvalid_holds: assert property ((bvalid && !bready) |=> bvalid)
    else $error("write response dropped");
  a_rvalid_holds: assert property ((rvalid && !rready) |=> rvalid && $stable(rdata))
    else $error("read data dropped");

endmodule // scr_chan_ctrl

// *** verilog/scr_defines.svh ***
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// Register byte addresses
`define SCR_ADDR_CHAN_A 32'h0003_0004
`define SCR_ADDR_CHAN_B 32'h0003_0014
`define SCR_ADDR_CHAN_C 32'h0003_0024
`define SCR_ADDR_CHAN_D 32'h0003_0034
`define SCR_ADDR_GLOBAL 32'h0003_0044
`define SCR_ADDR_IRQ_STAT 32'h0003_0048
`define SCR_ADDR_IRQ_MASK 32'h0003_004C

// Decoded register index
`define SCR_IDX_GLOBAL 3'h4
`define SCR_IDX_IRQ_STAT 3'h5
`define SCR_IDX_IRQ_MASK 3'h6
`define SCR_IDX_NONE 3'h7

// Reset values and writable-bit masks (bit 7 here is bit 0 of the MSB-first layout)
`define SCR_CHAN_RST 8'h40
`define SCR_CHAN_WMASK 8'h61
`define SCR_GLOBAL_RST 8'h44
`define SCR_GLOBAL_WMASK 8'h61
`define SCR_IRQ_MASK_RST 4'h0

`define SCR_NUM_CHAN 4
`define SCR_MIN_ADDR_W 18
`define SCR_MAX_ADDR_W 32

`define SCR_RESP_OKAY 2'h0
`define SCR_RESP_SLVERR 2'h2

`endif

// *** verilog/scr_pkg.sv ***
package scr_pkg;

  // Field order follows the MSB-first numbering: the first field is bit 0
  typedef struct packed {
    logic rsvd_lead;
    logic alarm_block;
    logic soft_reset;
    logic [3:0] rsvd_mid;
    logic test_enable;
  } scr_chan_ctrl_t;

  typedef struct packed {
    logic rsvd_lead;
    logic quad_alarm_block;
    logic quad_soft_reset;
    logic tx_power_down;
    logic rx_power_down;
    logic rsvd_five;
    logic rsvd_six;
    logic quad_test_override;
  } scr_global_ctrl_t;

  typedef enum logic [1:0] {
    SCR_WR_IDLE = 2'h0,
    SCR_WR_RESP = 2'h1
  } scr_wr_state_t;

  typedef enum logic [1:0] {
    SCR_RD_IDLE = 2'h0,
    SCR_RD_DATA = 2'h1
  } scr_rd_state_t;

  typedef struct packed {
    logic [3:0] tx;
    logic [3:0] rx;
  } scr_alarm_t;

endpackage

// *** verification/test_serdes_channel_control_regs.sv ***
`timescale 1ns/1ps
`include "scr_defines.svh"
module test_serdes_channel_control_regs import scr_pkg::*; ;
  localparam logic [1:0] OK = `SCR_RESP_OKAY;
  localparam logic [1:0] ER = `SCR_RESP_SLVERR;
  localparam logic [31:0] CHA = `SCR_ADDR_CHAN_A;
  localparam logic [31:0] GLB = `SCR_ADDR_GLOBAL;
  localparam logic [31:0] STA = `SCR_ADDR_IRQ_STAT;
  localparam logic [31:0] MSK = `SCR_ADDR_IRQ_MASK;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [19:0] awaddr = 20'h0;
  logic [19:0] araddr = 20'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  scr_alarm_t alarm = '0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] chan_soft_reset, chan_test_mode;
  int num_errors = 0;
  int samples_checked = 0;
  initial begin
    forever #25 aclk = ~aclk;
  end
  scr_chan_ctrl #(.ADDR_W(20)) DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .alarm(alarm), .chan_soft_reset(chan_soft_reset),
    .chan_test_mode(chan_test_mode), .irq(irq));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang();
    num_errors++;
    $display("BAD bus_answer expected answer seen none");
    end_of_test();
  endtask
  // Address and data are offered together; each drops once taken
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    awaddr <= a[19:0];
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) hang();
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    araddr <= a[19:0];
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) hang();
    chk("rdata", rdata, {24'h0, d});
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Held a few cycles so the one-cycle sampling of alarms cannot miss it
  task automatic pulse(input scr_alarm_t v);
    alarm <= v;
    repeat (3) @(posedge aclk);
    alarm <= '0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic outs(input logic [3:0] sr, input logic [3:0] tm);
    repeat (3) @(posedge aclk);
    chk("chan_soft_reset", {28'h0, chan_soft_reset}, {28'h0, sr});
    chk("chan_test_mode", {28'h0, chan_test_mode}, {28'h0, tm});
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    outs(4'h0, 4'h0);
    for (int i = 0; i < 4; i++) rd(CHA + 32'h10 * i, 8'h40, OK);
    rd(GLB, 8'h44, OK);
    rd(STA, 8'h00, OK);
    rd(MSK, 8'h00, OK);
    rd(32'h0003_0000, 8'h00, ER);
    wr(32'h0003_0000, 8'hFF, ER);
    $display("test reset_map done");
    wr(CHA, 8'h7F, OK);
    rd(CHA, 8'h61, OK);
    outs(4'h1, 4'h1);
    repeat (20) @(posedge aclk);
    rd(CHA, 8'h61, OK);
    wr(CHA, 8'h41, OK);
    outs(4'h0, 4'h1);
    wr(CHA + 32'h20, 8'h20, OK);
    outs(4'h4, 4'h1);
    wr(CHA + 32'h20, 8'h40, OK);
    $display("test channel_fields done");
    wr(GLB, 8'h45, OK);
    rd(GLB, 8'h45, OK);
    outs(4'h0, 4'hF);
    wr(GLB, 8'h64, OK);
    outs(4'hF, 4'h1);
    rd(CHA, 8'h41, OK);
    wr(GLB, 8'h04, OK);
    $display("test global_override done");
    wr(MSK, 8'h0F, OK);
    pulse('{tx: 4'h1, rx: 4'h0});
    rd(STA, 8'h00, OK);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(CHA, 8'h00, OK);
    pulse('{tx: 4'h0, rx: 4'h1});
    rd(STA, 8'h01, OK);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(MSK, 8'h00, OK);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(MSK, 8'h0F, OK);
    wr(STA, 8'h01, OK);
    rd(STA, 8'h00, OK);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(GLB, 8'h44, OK);
    pulse('{tx: 4'h1, rx: 4'h1});
    rd(STA, 8'h00, OK);
    $display("test interrupts done");
    end_of_test();
  end
endmodule // test_serdes_channel_control_regs
